/* src/hfp_consts.svh */
`ifndef HFP_CONSTS_SVH
`define HFP_CONSTS_SVH

// ==========================================================
// Host word indices (byte address = index * 4)
`define HFP_W_RXD_LO 6'h00
`define HFP_W_RXD_HI 6'h0f
`define HFP_W_TXD_LO 6'h10
`define HFP_W_TXD_HI 6'h1f
`define HFP_W_RXS_POP 6'h20
`define HFP_W_RXS_VIEW 6'h21
`define HFP_W_TXS_POP 6'h22
`define HFP_W_TXS_VIEW 6'h23
`define HFP_W_LEVEL 6'h24
`define HFP_W_EVENT 6'h25
`define HFP_W_CTRL 6'h26
`define HFP_W_SIZE 6'h27
`define HFP_W_CMD 6'h28

// ==========================================================
// Field positions
`define HFP_EV_RXS_OVF 0
`define HFP_EV_TXD_OVF 1
`define HFP_EV_RXD_UNDER 2
`define HFP_EV_LINK_HIGH 3
`define HFP_EV_LINK_LOW 4
`define HFP_CTRL_SRST 0
`define HFP_CTRL_RXEN 1
`define HFP_CTRL_WAKE 2
`define HFP_CMD_FLUSH_RXD 0
`define HFP_CMD_FLUSH_TXD 1
`define HFP_SIZE_RXD_LSB 0
`define HFP_SIZE_TXD_LSB 8
`define HFP_SIZE_RXS_LSB 16
`define HFP_SIZE_TXS_LSB 24

// ==========================================================
// Reset values
`define HFP_RXEN_RST 1'h0
`define HFP_WAKE_RST 1'h0
`define HFP_HOLD_RST 16'h0000

`endif

/* src/hfp_pkg.sv */
package hfp_pkg;

   typedef enum logic [3:0] {
      HFP_PORT_NONE = 4'h0,
      HFP_PORT_RXD = 4'h1,
      HFP_PORT_TXD = 4'h2,
      HFP_PORT_RXS_POP = 4'h3,
      HFP_PORT_RXS_VIEW = 4'h4,
      HFP_PORT_TXS_POP = 4'h5,
      HFP_PORT_TXS_VIEW = 4'h6,
      HFP_PORT_LEVEL = 4'h7,
      HFP_PORT_EVENT = 4'h8,
      HFP_PORT_CTRL = 4'h9,
      HFP_PORT_SIZE = 4'ha,
      HFP_PORT_CMD = 4'hb
   } hfp_port_t;

endpackage

/* src/hfp_fifo.sv */
`timescale 1ns/10ps
module hfp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   localparam int AW = $clog2(DEPTH),
   localparam int CW = AW + 1
) (
   input wire logic i_clk, // Clock
   input wire logic i_clr, // Synchronous clear
   input wire logic [CW-1:0] i_limit, // Usable entries, 0 means all
   input wire logic i_valid, // Fill side valid
   output logic o_ready, // Fill side ready
   input wire logic [WIDTH-1:0] i_data, // Fill side data
   output logic o_valid, // Drain side valid
   input wire logic i_ready, // Drain side ready
   output logic [WIDTH-1:0] o_data, // Drain side head entry
   output logic [CW-1:0] o_count // Entries held
);

   // ==========================================================
   // Storage and pointers (DEPTH must be a power of two)
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] wr_ptr;
   logic [CW-1:0] count;
   wire [CW-1:0] full_depth = CW'(DEPTH);
   wire [CW-1:0] eff_limit = (i_limit == '0 || i_limit > full_depth) ? full_depth : i_limit;
   wire push = i_valid & o_ready;
   wire pop = o_valid & i_ready;

   assign o_ready = count < eff_limit;
   assign o_valid = count != '0;
   assign o_data = mem[rd_ptr];
   assign o_count = count;

   always_ff @(posedge i_clk) begin
      if (i_clr) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else begin
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= rd_ptr + AW'(1);
         if (push && !pop)
            count <= count + CW'(1);
         else if (pop && !push)
            count <= count - CW'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (push)
         mem[wr_ptr] <= i_data;
   end

endmodule // hfp_fifo

/* src/hfp_ports.sv */
`timescale 1ns/10ps
`include "hfp_consts.svh"
module hfp_ports import hfp_pkg::*; #(
   parameter int DEPTH = 16,
   localparam int CW = $clog2(DEPTH) + 1
) (
   input wire logic i_clk, // 25 MHz clock
   input wire logic i_srst, // System reset, high
   input wire logic i_por, // Power-on reset, high
   input wire logic i_cs, // Host chip select
   input wire logic i_rd, // Host read strobe
   input wire logic i_wr, // Host write strobe
   input wire logic [7:1] i_addr, // Host half-word address
   input wire logic [15:0] i_wdata, // Host write data
   output logic [15:0] o_rdata, // Host read data
   output logic o_rvalid, // Read data valid pulse
   input wire logic i_rxs_valid, // Receive status push valid
   output logic o_rxs_ready, // Receive status push ready
   input wire logic [31:0] i_rxs_data, // Receive status entry
   input wire logic i_rxd_valid, // Receive data push valid
   output logic o_rxd_ready, // Receive data push ready
   input wire logic [31:0] i_rxd_data, // Receive data word
   input wire logic i_txs_valid, // Transmit status push valid
   output logic o_txs_ready, // Transmit status push ready
   input wire logic [31:0] i_txs_data, // Transmit status entry
   output logic o_txd_valid, // Transmit data valid
   input wire logic i_txd_ready, // Transmit data taken
   output logic [31:0] o_txd_data, // Transmit data word
   input wire logic i_link_up, // Link state level
   output logic o_rx_enable, // Receive path enabled
   output logic o_wake_cfg // Wake configuration bit
);

   // ==========================================================
   // Address decode
   function automatic hfp_port_t hfp_decode(input logic [5:0] w);
      hfp_port_t p;
      p = HFP_PORT_NONE;
      if (w >= `HFP_W_RXD_LO && w <= `HFP_W_RXD_HI)
         p = HFP_PORT_RXD;
      else if (w >= `HFP_W_TXD_LO && w <= `HFP_W_TXD_HI)
         p = HFP_PORT_TXD;
      else begin
         case (w)
            `HFP_W_RXS_POP: p = HFP_PORT_RXS_POP;
            `HFP_W_RXS_VIEW: p = HFP_PORT_RXS_VIEW;
            `HFP_W_TXS_POP: p = HFP_PORT_TXS_POP;
            `HFP_W_TXS_VIEW: p = HFP_PORT_TXS_VIEW;
            `HFP_W_LEVEL: p = HFP_PORT_LEVEL;
            `HFP_W_EVENT: p = HFP_PORT_EVENT;
            `HFP_W_CTRL: p = HFP_PORT_CTRL;
            `HFP_W_SIZE: p = HFP_PORT_SIZE;
            `HFP_W_CMD: p = HFP_PORT_CMD;
            default: p = HFP_PORT_NONE;
         endcase
      end
      return p;
   endfunction

   function automatic logic [7:0] hfp_lane(input logic [CW-1:0] c);
      return 8'(c);
   endfunction

   wire hfp_port_t sel = hfp_decode(i_addr[7:2]);
   wire hi_half = i_addr[1];
   wire rd_lo = i_cs & i_rd & ~hi_half;
   wire rd_hi = i_cs & i_rd & hi_half;
   wire wr_lo = i_cs & i_wr & ~hi_half;
   wire wr_hi = i_cs & i_wr & hi_half;

   // ==========================================================
   // Resets
   logic soft_rst;
   wire hard_rst = i_srst | i_por;
   wire any_rst = hard_rst | soft_rst;

   // ==========================================================
   // Write pairing: low half parked, high half commits
   logic [15:0] wr_low;
   wire [31:0] wr_word = {i_wdata, wr_low};
   wire wr_ctrl = wr_hi && sel == HFP_PORT_CTRL;
   wire wr_size = wr_hi && sel == HFP_PORT_SIZE;
   wire wr_cmd = wr_hi && sel == HFP_PORT_CMD;
   wire wr_event = wr_hi && sel == HFP_PORT_EVENT;

   // ==========================================================
   // Queues
   logic rx_enable;
   logic wake_cfg;
   logic [31:0] size_cfg;
   logic rxs_vld, rxd_vld, txs_vld, rxs_in_rdy, rxd_in_rdy, txd_in_rdy;
   logic [31:0] rxs_q, rxd_q, txs_q;
   logic [CW-1:0] rxs_cnt, rxd_cnt, txs_cnt, txd_cnt;

   wire pop_rxs = rd_hi && sel == HFP_PORT_RXS_POP && rxs_vld;
   wire pop_rxd = rd_hi && sel == HFP_PORT_RXD && rxd_vld;
   wire pop_txs = rd_hi && sel == HFP_PORT_TXS_POP && txs_vld;
   wire push_txd = wr_hi && sel == HFP_PORT_TXD;
   wire flush_rxd = wr_cmd & wr_word[`HFP_CMD_FLUSH_RXD];
   wire flush_txd = wr_cmd & wr_word[`HFP_CMD_FLUSH_TXD];
   wire rxs_push = i_rxs_valid & o_rxs_ready;
   wire rxd_push = i_rxd_valid & o_rxd_ready;

   assign o_rxs_ready = rxs_in_rdy & rx_enable;
   assign o_rxd_ready = rxd_in_rdy & rx_enable;

   hfp_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rxs_fifo (
      .i_clk(i_clk),
      .i_clr(any_rst),
      .i_limit(CW'(size_cfg[`HFP_SIZE_RXS_LSB +: 8])),
      .i_valid(i_rxs_valid & rx_enable),
      .o_ready(rxs_in_rdy),
      .i_data(i_rxs_data),
      .o_valid(rxs_vld),
      .i_ready(pop_rxs),
      .o_data(rxs_q),
      .o_count(rxs_cnt)
   );

   hfp_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rxd_fifo (
      .i_clk(i_clk),
      .i_clr(any_rst | flush_rxd),
      .i_limit(CW'(size_cfg[`HFP_SIZE_RXD_LSB +: 8])),
      .i_valid(i_rxd_valid & rx_enable),
      .o_ready(rxd_in_rdy),
      .i_data(i_rxd_data),
      .o_valid(rxd_vld),
      .i_ready(pop_rxd),
      .o_data(rxd_q),
      .o_count(rxd_cnt)
   );

   hfp_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_txs_fifo (
      .i_clk(i_clk),
      .i_clr(any_rst),
      .i_limit(CW'(size_cfg[`HFP_SIZE_TXS_LSB +: 8])),
      .i_valid(i_txs_valid),
      .o_ready(o_txs_ready),
      .i_data(i_txs_data),
      .o_valid(txs_vld),
      .i_ready(pop_txs),
      .o_data(txs_q),
      .o_count(txs_cnt)
   );

   hfp_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_txd_fifo (
      .i_clk(i_clk),
      .i_clr(any_rst | flush_txd),
      .i_limit(CW'(size_cfg[`HFP_SIZE_TXD_LSB +: 8])),
      .i_valid(push_txd),
      .o_ready(txd_in_rdy),
      .i_data(wr_word),
      .o_valid(o_txd_valid),
      .i_ready(i_txd_ready),
      .o_data(o_txd_data),
      .o_count(txd_cnt)
   );

   // ==========================================================
   // Event status
   logic rxs_ovf, txd_ovf, rxd_under, link_high_seen, link_low_seen;
   wire ev_read = rd_hi && sel == HFP_PORT_EVENT;
   wire rxs_drop = i_rxs_valid & rx_enable & ~rxs_in_rdy;
   wire txd_drop = push_txd & ~txd_in_rdy;
   wire under_ev = rd_hi && sel == HFP_PORT_RXD && !rxd_vld;
   wire clr_rxs_ovf = wr_event & wr_word[`HFP_EV_RXS_OVF];
   wire clr_txd_ovf = wr_event & wr_word[`HFP_EV_TXD_OVF];
   wire [31:0] event_word = {27'h0, ~link_low_seen, link_high_seen, rxd_under, txd_ovf, rxs_ovf};

   always_ff @(posedge i_clk) begin
      if (any_rst) begin
         rxs_ovf <= 1'b0;
         txd_ovf <= 1'b0;
         rxd_under <= 1'b0;
         link_high_seen <= 1'b0;
         link_low_seen <= 1'b0;
      end else begin
         rxs_ovf <= (rxs_ovf & ~clr_rxs_ovf) | rxs_drop;
         txd_ovf <= (txd_ovf & ~clr_txd_ovf) | txd_drop;
         rxd_under <= (rxd_under & ~ev_read) | under_ev;
         link_high_seen <= (link_high_seen & ~ev_read) | i_link_up;
         link_low_seen <= (link_low_seen & ~ev_read) | ~i_link_up;
      end
   end

   // ==========================================================
   // Control, size and reset registers
   always_ff @(posedge i_clk) begin
      if (hard_rst)
         soft_rst <= 1'b0;
      else
         soft_rst <= wr_ctrl & wr_word[`HFP_CTRL_SRST];
   end

   always_ff @(posedge i_clk) begin
      if (any_rst) begin
         rx_enable <= `HFP_RXEN_RST;
         size_cfg <= {4{hfp_lane(CW'(DEPTH))}};
         wr_low <= `HFP_HOLD_RST;
      end else begin
         if (wr_ctrl)
            rx_enable <= wr_word[`HFP_CTRL_RXEN];
         if (wr_size)
            size_cfg <= wr_word;
         if (wr_lo)
            wr_low <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (hard_rst)
         wake_cfg <= `HFP_WAKE_RST;
      else if (wr_ctrl)
         wake_cfg <= wr_word[`HFP_CTRL_WAKE];
   end

   assign o_rx_enable = rx_enable;
   assign o_wake_cfg = wake_cfg;

   // ==========================================================
   // Read selection: write-only and unmapped locations read zero
   wire [31:0] level_word = {hfp_lane(txd_cnt), hfp_lane(txs_cnt), hfp_lane(rxd_cnt), hfp_lane(rxs_cnt)};
   wire [31:0] ctrl_word = {29'h0, wake_cfg, rx_enable, 1'b0};
   wire [31:0] rxd_word = rxd_vld ? rxd_q : 32'h0;
   wire [31:0] rxs_word = rxs_vld ? rxs_q : 32'h0;
   wire [31:0] txs_word = txs_vld ? txs_q : 32'h0;
   wire [31:0] rd_word =
      (sel == HFP_PORT_RXD) ? rxd_word :
      (sel == HFP_PORT_RXS_POP || sel == HFP_PORT_RXS_VIEW) ? rxs_word :
      (sel == HFP_PORT_TXS_POP || sel == HFP_PORT_TXS_VIEW) ? txs_word :
      (sel == HFP_PORT_LEVEL) ? level_word :
      (sel == HFP_PORT_EVENT) ? event_word :
      (sel == HFP_PORT_CTRL) ? ctrl_word :
      (sel == HFP_PORT_SIZE) ? size_cfg :
      32'h0;

   // ==========================================================
   // Read pairing: low half captures the word, high half returns the rest
   logic [15:0] rd_high;
   always_ff @(posedge i_clk) begin
      if (any_rst) begin
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
         rd_high <= `HFP_HOLD_RST;
      end else begin
         o_rvalid <= rd_lo | rd_hi;
         if (rd_lo) begin
            o_rdata <= rd_word[15:0];
            rd_high <= rd_word[31:16];
         end else if (rd_hi) begin
            o_rdata <= rd_high;
         end
      end
   end

   // ==========================================================
   // Checks
   a_ro_write_ignored: assert property (@(posedge i_clk) disable iff (any_rst)
      (wr_hi && (sel == HFP_PORT_RXD || sel == HFP_PORT_RXS_POP) && !rxd_push && !rxs_push)
      |=> (rxd_cnt == $past(rxd_cnt) && rxs_cnt == $past(rxs_cnt)))
      else $error("write to read-only port changed a queue");

   a_wo_read_zero: assert property (@(posedge i_clk) disable iff (any_rst)
      (i_cs && i_rd && (sel == HFP_PORT_TXD || sel == HFP_PORT_CMD) && !hi_half)
      |=> (o_rvalid && o_rdata == 16'h0000))
      else $error("write-only port read non-zero");

   a_w1c_clear_keep: assert property (@(posedge i_clk) disable iff (any_rst)
      (wr_event && !rxs_drop && !txd_drop && !soft_rst)
      |=> (rxs_ovf == ($past(rxs_ovf) && !$past(wr_word[`HFP_EV_RXS_OVF]))
         && txd_ovf == ($past(txd_ovf) && !$past(wr_word[`HFP_EV_TXD_OVF]))))
      else $error("write-one-clear bit wrong after write");

   a_cor_clears: assert property (@(posedge i_clk) disable iff (any_rst)
      (ev_read && rxd_under) |=> !rxd_under)
      else $error("clear-on-read bit survived read");

   a_latch_high_hold: assert property (@(posedge i_clk) disable iff (any_rst)
      (i_link_up ##1 (!ev_read && !i_link_up)) |=> link_high_seen)
      else $error("latch-high bit lost before read");

   a_exempt_kept: assert property (@(posedge i_clk) disable iff (hard_rst)
      soft_rst |=> (wake_cfg == $past(wake_cfg) && rx_enable == `HFP_RXEN_RST))
      else $error("software reset disturbed exempt bit");

   a_soft_defaults: assert property (@(posedge i_clk) disable iff (hard_rst)
      (wr_ctrl && wr_word[0]) |=> ##1 (rxs_cnt == '0 && !rxs_ovf && size_cfg[7:0] == hfp_lane(CW'(DEPTH))))
      else $error("software reset left a register off default");

   a_rxs_pop_once: assert property (@(posedge i_clk) disable iff (any_rst)
      (pop_rxs && !rxs_push) |=> rxs_cnt + CW'(1) == $past(rxs_cnt))
      else $error("status pop did not remove one entry");

   a_view_keeps: assert property (@(posedge i_clk) disable iff (any_rst)
      (rd_hi && sel == HFP_PORT_RXS_VIEW && !rxs_push) |=> $stable(rxs_cnt))
      else $error("view port removed an entry");

   a_rxd_alias_pop: assert property (@(posedge i_clk) disable iff (any_rst)
      (pop_rxd && !rxd_push && !flush_rxd) |=> rxd_cnt + CW'(1) == $past(rxd_cnt))
      else $error("receive data read did not pop");

   a_txd_push_once: assert property (@(posedge i_clk) disable iff (any_rst)
      (push_txd && txd_in_rdy && !(o_txd_valid && i_txd_ready)) |=> txd_cnt == $past(txd_cnt) + CW'(1))
      else $error("transmit data write did not push");

   a_low_half_quiet: assert property (@(posedge i_clk) disable iff (any_rst)
      (rd_lo && !rxd_push) |=> $stable(rxd_cnt))
      else $error("first half access moved a queue");

   a_pair_return: assert property (@(posedge i_clk) disable iff (any_rst)
      (rd_lo ##1 (rd_hi && !rd_lo)) |=> o_rdata == $past(rd_word[31:16], 2))
      else $error("second half did not return upper half of word");

endmodule // hfp_ports

/* testbench/hfp_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Host processor on the 16-bit bus
module hfp_host_model (
   input wire logic i_clk, // Clock
   output logic o_cs, // Chip select
   output logic o_rd, // Read strobe
   output logic o_wr, // Write strobe
   output logic [7:1] o_addr, // Half-word address
   output logic [15:0] o_wdata, // Write data
   input wire logic [15:0] i_rdata, // Read data
   input wire logic i_rvalid // Read data valid pulse
);
   int gap = 0;

   initial begin
      o_cs = 1'b0;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 7'h00;
      o_wdata = 16'h0000;
   end

   task automatic put(input logic r, input logic w, input logic [7:1] a, input logic [15:0] d);
      @(posedge i_clk);
      o_cs <= 1'b1;
      o_rd <= r;
      o_wr <= w;
      o_addr <= a;
      o_wdata <= d;
   endtask

   // Released lines flip so stale values never look valid
   task automatic idle();
      @(posedge i_clk);
      o_cs <= 1'b0;
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
   endtask

   // Low half first, then high half, one word per pair
   task automatic rd32(input logic [5:0] w, output logic [31:0] d);
      put(1'b1, 1'b0, {w, 1'b0}, ~o_wdata);
      put(1'b1, 1'b0, {w, 1'b1}, ~o_wdata);
      @(negedge i_clk);
      d[15:0] = i_rvalid ? i_rdata : 16'hxxxx;
      idle();
      @(negedge i_clk);
      d[31:16] = i_rvalid ? i_rdata : 16'hxxxx;
      repeat (gap) @(posedge i_clk);
   endtask

   // All 32 bits of d are written to word w, low half first, then high half
   task automatic wr32(input logic [5:0] w, input logic [31:0] d);
      put(1'b0, 1'b1, {w, 1'b0}, d[15:0]);
      put(1'b0, 1'b1, {w, 1'b1}, d[31:16]);
      idle();
      repeat (gap) @(posedge i_clk);
   endtask
endmodule // hfp_host_model

/* testbench/hfp_ports_bench.sv */
`timescale 1ns/10ps
`include "hfp_consts.svh"
module hfp_ports_bench;
   localparam int DEPTH = 16;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic por = 1'b0;
   logic cs, rd, wr, rvalid, txd_v, rx_en, wake;
   logic [7:1] addr;
   logic [15:0] wdata, rdata;
   logic [2:0] pv = 3'h0;
   logic [31:0] pd [3] = '{32'h0, 32'h0, 32'h0};
   wire [2:0] pr;
   logic txd_r = 1'b0;
   logic link = 1'b0;
   logic [31:0] txd_d, v;
   logic [31:0] q[$];
   int n_errors = 0;
   int checks = 0;

   always #20 clk = ~clk;

   hfp_ports #(.DEPTH(DEPTH)) dut_u (.i_clk(clk), .i_srst(srst), .i_por(por), .i_cs(cs), .i_rd(rd),
      .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
      .i_rxs_valid(pv[0]), .o_rxs_ready(pr[0]), .i_rxs_data(pd[0]), .i_rxd_valid(pv[1]),
      .o_rxd_ready(pr[1]), .i_rxd_data(pd[1]), .i_txs_valid(pv[2]), .o_txs_ready(pr[2]),
      .i_txs_data(pd[2]), .o_txd_valid(txd_v), .i_txd_ready(txd_r), .o_txd_data(txd_d),
      .i_link_up(link), .o_rx_enable(rx_en), .o_wake_cfg(wake));

   hfp_host_model host_u (.i_clk(clk), .o_cs(cs), .o_rd(rd), .o_wr(wr), .o_addr(addr),
      .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [5:0] w, input logic [31:0] exp);
      host_u.rd32(w, v);
      chk(v, exp);
   endtask

   task automatic push(input int s, input logic [31:0] d, output bit ok);
      @(posedge clk);
      pv[s] <= 1'b1;
      pd[s] <= d;
      @(negedge clk);
      ok = (pr[s] === 1'b1);
      @(posedge clk);
      pv[s] <= 1'b0;
      pd[s] <= ~d;
   endtask

   task automatic do_reset(input bit p);
      @(posedge clk);
      if (p) por <= 1'b1;
      else srst <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      por <= 1'b0;
   endtask

   task automatic end_sim();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      int i, g;
      bit ok;
      logic [31:0] a, b, d;
      logic [5:0] w;
      v = $urandom(84);
      do_reset(1'b0);
      rdchk(`HFP_W_LEVEL, 32'h00000000);
      rdchk(`HFP_W_CTRL, 32'h00000000);
      rdchk(`HFP_W_SIZE, {4{DEPTH[7:0]}});
      rdchk(`HFP_W_CMD, 32'h00000000);
      rdchk(`HFP_W_TXD_LO + 6'h3, 32'h00000000);
      $display("test defaults done");
      host_u.gap = $urandom_range(2, 0);
      host_u.wr32(`HFP_W_CTRL, 32'h00000006);
      @(negedge clk);
      chk({rx_en, wake}, 32'h00000003);
      host_u.wr32(`HFP_W_SIZE, {{3{DEPTH[7:0]}}, 8'h04});
      for (i = 0; i < 6; i++) begin
         d = $urandom;
         push(1, d, ok);
         if (ok) q.push_back(d);
      end
      chk(q.size(), 32'h00000004);
      host_u.wr32(`HFP_W_SIZE, {4{DEPTH[7:0]}});
      for (i = 0; i < 14; i++) begin
         d = $urandom;
         push(1, d, ok);
         if (ok) q.push_back(d);
      end
      chk(q.size(), 32'h00000010);
      rdchk(`HFP_W_LEVEL, 32'h00001000);
      for (i = 0; i < 16; i++) rdchk(6'(i), q.pop_front());
      rdchk(`HFP_W_RXD_LO, 32'h00000000);
      rdchk(`HFP_W_EVENT, 32'h00000004);
      rdchk(`HFP_W_EVENT, 32'h00000000);
      $display("test receive data done");
      for (i = 0; i < 3; i += 2) begin
         a = $urandom;
         b = $urandom;
         push(i, a, ok);
         push(i, b, ok);
         w = (i == 0) ? `HFP_W_RXS_POP : `HFP_W_TXS_POP;
         rdchk(w + 6'h1, a);
         rdchk(w + 6'h1, a);
         rdchk(w, a);
         rdchk(w + 6'h1, b);
         rdchk(w, b);
      end
      rdchk(`HFP_W_LEVEL, 32'h00000000);
      $display("test status queues done");
      for (i = 0; i < 17; i++) begin
         d = $urandom;
         host_u.wr32(`HFP_W_TXD_LO + 6'(i % 16), d);
         if (i < 16) q.push_back(d);
      end
      rdchk(`HFP_W_LEVEL, 32'h10000000);
      host_u.wr32(`HFP_W_LEVEL, 32'hffffffff);
      host_u.wr32(`HFP_W_RXD_LO + 6'h5, 32'hffffffff);
      rdchk(`HFP_W_LEVEL, 32'h10000000);
      rdchk(`HFP_W_EVENT, 32'h00000002);
      host_u.wr32(`HFP_W_EVENT, 32'h00000000);
      rdchk(`HFP_W_EVENT, 32'h00000002);
      host_u.wr32(`HFP_W_EVENT, 32'h00000002);
      rdchk(`HFP_W_EVENT, 32'h00000000);
      g = 0;
      while (q.size() > 0 && g < 500) begin
         @(posedge clk);
         txd_r <= 1'($urandom_range(1, 0));
         @(negedge clk);
         if (txd_v === 1'b1 && txd_r === 1'b1) chk(txd_d, q.pop_front());
         g++;
      end
      @(posedge clk);
      txd_r <= 1'b0;
      @(negedge clk);
      chk(q.size(), 32'h00000000);
      chk(txd_v, 32'h00000000);
      $display("test transmit data done");
      @(posedge clk);
      link <= 1'b1;
      rdchk(`HFP_W_EVENT, 32'h00000008);
      rdchk(`HFP_W_EVENT, 32'h00000018);
      @(posedge clk);
      link <= 1'b0;
      host_u.rd32(`HFP_W_EVENT, v);
      chk(v & 32'h00000018, 32'h00000008);
      host_u.rd32(`HFP_W_EVENT, v);
      chk(v & 32'h00000018, 32'h00000000);
      $display("test link latch done");
      host_u.wr32(`HFP_W_TXD_LO, $urandom);
      host_u.wr32(`HFP_W_SIZE, 32'h04040404);
      host_u.wr32(`HFP_W_CTRL, 32'h00000007);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({rx_en, wake, txd_v}, 32'h00000002);
      rdchk(`HFP_W_LEVEL, 32'h00000000);
      rdchk(`HFP_W_SIZE, {4{DEPTH[7:0]}});
      rdchk(`HFP_W_CTRL, 32'h00000004);
      do_reset(1'b1);
      @(negedge clk);
      chk({rx_en, wake}, 32'h00000000);
      $display("test resets done");
      end_sim();
   end

   initial begin
      #1000000;
      n_errors++;
      end_sim();
   end
endmodule // hfp_ports_bench
